// *** rtl/vid_cfg_consts.svh ***
`ifndef VID_CFG_CONSTS_SVH
`define VID_CFG_CONSTS_SVH

// command codes of the two registers
`define CMD_TEMP_MAX_DEFAULT    8'hc1
`define CMD_PROTO_BOOT_BCAST    8'hc2

// link-side register indices
`define LINK_IDX_PROTOCOL       8'h05
`define LINK_IDX_BCAST_ACT      8'h0f
`define LINK_IDX_TEMP_MAX       8'h22
`define LINK_IDX_VBOOT          8'h26

// field positions
`define TEMP_FIELD_MSB          2
`define TEMP_FIELD_LSB          0
`define PROTO_FIELD_MSB         7
`define PROTO_FIELD_LSB         6
`define VBOOT_FIELD_MSB         5
`define VBOOT_FIELD_LSB         2
`define BCAST_FIELD_MSB         1
`define BCAST_FIELD_LSB         0

// reserved bits of the temperature register read back as this
`define TEMP_RSVD_VALUE         5'h00

// temperature decode: base and step in degrees C
`define TEMP_BASE_C             8'h5f
`define TEMP_STEP_C             8'h05

// link protocol codes
`define LINK_PROTO_10MV         8'h04
`define LINK_PROTO_5MV_A        8'h07
`define LINK_PROTO_5MV_B        8'h09

// setpoint resolutions in mV per lsb
`define STEP_10MV               4'ha
`define STEP_5MV                4'h5

// lowest boot code that needs the 10 mV protocols
`define VBOOT_HI_MIN            4'hd

// broadcast addresses
`define BCAST_ADDR_E            8'h0e
`define BCAST_ADDR_F            8'h0f

`endif

// *** rtl/vid_cfg_pkg.sv ***
package vid_cfg_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    PROTO_STD_10MV,
    PROTO_STD_5MV,
    PROTO_ALT_5MV,
    PROTO_ALT_10MV
  } proto_sel_e;

  typedef enum {
    CFG_WAIT_NVM,
    CFG_READY
  } cfg_state_e;

endpackage

// *** rtl/vboot_vid_lut.sv ***
`timescale 1ns/1ps

// boot code to link voltage-identification code
module vboot_vid_lut (
  // lookup
  input  wire logic [3:0] vboot_code,
  output logic      [7:0] vid_code
);

  always_comb begin
    case (vboot_code)
      4'h0:    vid_code = 8'h00;
      4'h1:    vid_code = 8'h65;
      4'h2:    vid_code = 8'h6f;
      4'h3:    vid_code = 8'h79;
      4'h4:    vid_code = 8'h83;
      4'h5:    vid_code = 8'h8d;
      4'h6:    vid_code = 8'h97;
      4'h7:    vid_code = 8'ha1;
      4'h8:    vid_code = 8'hab;
      4'h9:    vid_code = 8'haf;
      4'ha:    vid_code = 8'hc9;
      4'hb:    vid_code = 8'hdd;
      4'hc:    vid_code = 8'hfb;
      4'hd:    vid_code = 8'h6f;
      4'he:    vid_code = 8'h79;
      4'hf:    vid_code = 8'h83;
      default: vid_code = 8'h00;
    endcase
  end

endmodule

// *** rtl/vid_link_config_registers.sv ***
`timescale 1ns/1ps
`include "vid_cfg_consts.svh"

module vid_link_config_registers (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // command port from the serial engine
  input  wire logic       wr_req,
  input  wire logic       rd_req,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] wr_data,
  output logic            cmd_hit,
  output logic            wr_ack,
  output logic            wr_nack,
  output logic      [7:0] rd_data,
  // non-volatile store
  input  wire logic       nvm_load,
  input  wire logic [7:0] nvm_temp_max,
  input  wire logic [7:0] nvm_proto_cfg,
  // converter state
  input  wire logic       conv_enabled,
  input  wire logic [1:0] voltage_control_source,
  // link-side copies
  output logic            link_ready,
  output logic      [7:0] link_temp_max,
  output logic      [7:0] link_protocol_select,
  output logic      [7:0] link_vboot_vid,
  output logic      [7:0] broadcast_activation_reg,
  // decoded settings
  output logic      [7:0] temp_max_report_c,
  output logic      [3:0] output_voltage_setpoint_step_mv,
  output logic      [3:0] vboot_code,
  output logic            vboot_apply,
  output logic            answer_bcast_e,
  output logic            answer_bcast_f
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  vid_cfg_pkg::cfg_state_e state_ff;
  vid_cfg_pkg::cfg_state_e nxt_state;
  logic [2:0] temp_ff;
  logic [1:0] proto_wr_ff;
  logic [3:0] vboot_ff;
  logic [1:0] bcast_wr_ff;
  logic [1:0] proto_eff_ff;
  logic [1:0] bcast_eff_ff;
  logic [7:0] link_temp_ff;
  logic [7:0] link_proto_ff;
  logic [7:0] link_vboot_ff;
  logic [7:0] link_bcast_ff;
  logic [7:0] rd_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire        hit_temp   = (cmd_code == `CMD_TEMP_MAX_DEFAULT);
  wire        hit_proto  = (cmd_code == `CMD_PROTO_BOOT_BCAST);
  wire        ready      = (state_ff == vid_cfg_pkg::CFG_READY);
  wire [1:0]  wr_proto   = wr_data[`PROTO_FIELD_MSB:`PROTO_FIELD_LSB];
  wire [3:0]  wr_vboot   = wr_data[`VBOOT_FIELD_MSB:`VBOOT_FIELD_LSB];
  wire        proto_10mv = (wr_proto == 2'h0) || (wr_proto == 2'h3);
  wire        boot_hi    = (wr_vboot >= `VBOOT_HI_MIN);
  wire        boot_fits  = (boot_hi == proto_10mv);
  wire        wr_temp_ok  = wr_req && ready && hit_temp;
  wire        wr_proto_ok = wr_req && ready && hit_proto && boot_fits;
  wire        hold_back  = conv_enabled;
  wire [7:0]  vid_of_boot;
  wire [7:0]  nvm_vid;
  wire [7:0]  eff_proto_code;
  wire [7:0]  eff_bcast_copy;
  wire [7:0]  rd_mux;

  assign cmd_hit = hit_temp || hit_proto;
  assign wr_ack  = wr_temp_ok || wr_proto_ok;
  assign wr_nack = wr_req && hit_proto && ready && !boot_fits;

  function automatic logic [7:0] proto_code(input logic [1:0] sel);
    case (sel)
      2'h0:    proto_code = `LINK_PROTO_10MV;
      2'h1:    proto_code = `LINK_PROTO_5MV_A;
      2'h2:    proto_code = `LINK_PROTO_5MV_B;
      default: proto_code = `LINK_PROTO_10MV;
    endcase
  endfunction

  assign eff_proto_code = proto_code(proto_eff_ff);
  assign eff_bcast_copy = {6'h00, bcast_eff_ff};

  vboot_vid_lut u_vid_live (
    .vboot_code (vboot_ff),
    .vid_code   (vid_of_boot)
  );

  vboot_vid_lut u_vid_nvm (
    .vboot_code (nvm_proto_cfg[`VBOOT_FIELD_MSB:`VBOOT_FIELD_LSB]),
    .vid_code   (nvm_vid)
  );

  // reserved temperature bits never come from a stored value
  assign rd_mux = hit_temp  ? {`TEMP_RSVD_VALUE, temp_ff} :
                  hit_proto ? {proto_wr_ff, vboot_ff, bcast_wr_ff} :
                  8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // load sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      vid_cfg_pkg::CFG_WAIT_NVM: begin
        if (nvm_load) begin
          nxt_state = vid_cfg_pkg::CFG_READY;
        end
      end
      vid_cfg_pkg::CFG_READY: nxt_state = vid_cfg_pkg::CFG_READY;
      default: nxt_state = vid_cfg_pkg::CFG_WAIT_NVM;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= vid_cfg_pkg::CFG_WAIT_NVM;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host-visible fields
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_ff     <= 3'h0;
      proto_wr_ff <= 2'h0;
      vboot_ff    <= 4'h0;
      bcast_wr_ff <= 2'h0;
    end else if (!ready && nvm_load) begin
      temp_ff     <= nvm_temp_max[`TEMP_FIELD_MSB:`TEMP_FIELD_LSB];
      proto_wr_ff <= nvm_proto_cfg[`PROTO_FIELD_MSB:`PROTO_FIELD_LSB];
      vboot_ff    <= nvm_proto_cfg[`VBOOT_FIELD_MSB:`VBOOT_FIELD_LSB];
      bcast_wr_ff <= nvm_proto_cfg[`BCAST_FIELD_MSB:`BCAST_FIELD_LSB];
    end else begin
      if (wr_temp_ok) begin
        temp_ff <= wr_data[`TEMP_FIELD_MSB:`TEMP_FIELD_LSB];
      end
      if (wr_proto_ok) begin
        proto_wr_ff <= wr_proto;
        vboot_ff    <= wr_vboot;
        bcast_wr_ff <= wr_data[`BCAST_FIELD_MSB:`BCAST_FIELD_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective fields, held while converting
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      proto_eff_ff <= 2'h0;
      bcast_eff_ff <= 2'h0;
    end else if (!ready && nvm_load) begin
      proto_eff_ff <= nvm_proto_cfg[`PROTO_FIELD_MSB:`PROTO_FIELD_LSB];
      bcast_eff_ff <= nvm_proto_cfg[`BCAST_FIELD_MSB:`BCAST_FIELD_LSB];
    end else if (!hold_back) begin
      proto_eff_ff <= proto_wr_ff;
      bcast_eff_ff <= bcast_wr_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link-side copies
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_temp_ff  <= 8'h00;
      link_proto_ff <= 8'h00;
      link_vboot_ff <= 8'h00;
      link_bcast_ff <= 8'h00;
    end else if (!ready && nvm_load) begin
      link_temp_ff  <= {5'h00, nvm_temp_max[2:0]};
      link_proto_ff <= proto_code(nvm_proto_cfg[7:6]);
      link_vboot_ff <= nvm_vid;
      link_bcast_ff <= {6'h00, nvm_proto_cfg[1:0]};
    end else begin
      if (wr_temp_ok) begin
        link_temp_ff <= {5'h00, wr_data[2:0]};
      end
      link_proto_ff <= eff_proto_code;
      link_vboot_ff <= vid_of_boot;
      link_bcast_ff <= eff_bcast_copy;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= 8'h00;
    end else if (rd_req) begin
      rd_data_ff <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the temperature drives only the report, the read-back rd_data and the link copy link_temp_max
  assign link_ready               = ready;
  assign link_temp_max            = link_temp_ff;
  assign link_protocol_select     = link_proto_ff;
  assign link_vboot_vid           = link_vboot_ff;
  assign broadcast_activation_reg = link_bcast_ff;
  assign rd_data                  = rd_data_ff;
  assign temp_max_report_c = 8'(`TEMP_BASE_C + 8'(temp_ff) * `TEMP_STEP_C);
  assign output_voltage_setpoint_step_mv =
    ((proto_eff_ff == 2'h0) || (proto_eff_ff == 2'h3)) ?
    `STEP_10MV : `STEP_5MV;
  assign vboot_code     = vboot_ff;
  assign vboot_apply    = (voltage_control_source == 2'h0) ||
                          (voltage_control_source == 2'h1);
  assign answer_bcast_e = bcast_eff_ff[1];
  assign answer_bcast_f = bcast_eff_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  temp_copy_a: assert property (
    wr_temp_ok |=> link_temp_max == {5'h00, $past(wr_data[2:0])})
    else $error("temperature copy missed");
  temp_rsvd_a: assert property (
    rd_req && hit_temp |=> rd_data[7:3] == 5'h00)
    else $error("reserved temperature bits not zero");
  temp_decode_a: assert property (
    temp_max_report_c == 8'h5f + 8'({5'h00, temp_ff} * 8'h05))
    else $error("temperature decode wrong");
  boot_nack_a: assert property (
    wr_req && ready && hit_proto && (wr_vboot >= 4'hd) &&
    (wr_proto == 2'h1 || wr_proto == 2'h2) |-> wr_nack && !wr_ack)
    else $error("mismatched boot code not refused");
  boot_low_a: assert property (
    wr_req && ready && hit_proto && (wr_vboot < 4'hd) &&
    (wr_proto == 2'h1 || wr_proto == 2'h2) |-> wr_ack)
    else $error("matching boot code refused");
  hold_proto_a: assert property (
    conv_enabled && $past(conv_enabled) && $past(conv_enabled, 2)
    |-> $stable(link_protocol_select))
    else $error("protocol changed while converting");
  proto_code_a: assert property (
    ready && !conv_enabled && proto_wr_ff == 2'h2 ##1 !conv_enabled
    |=> link_protocol_select == 8'h09)
    else $error("protocol code wrong");
  step_res_a: assert property (
    ready && $past(ready) |->
    ((link_protocol_select == 8'h04) ==
     ($past(output_voltage_setpoint_step_mv) == 4'ha)))
    else $error("step size wrong");
  vboot_now_a: assert property (
    wr_proto_ok |=> vboot_code == $past(wr_vboot))
    else $error("boot field not updated");
  bcast_copy_a: assert property (
    ready |-> ##1 broadcast_activation_reg ==
    {6'h00, $past(answer_bcast_e), $past(answer_bcast_f)})
    else $error("broadcast copy wrong");

endmodule

// *** testbench/vid_cfg_store_model.sv ***
`timescale 1ns/1ps

// non-volatile store: presents its contents and pulses the load after reset
module vid_cfg_store_model #(
  parameter logic [7:0] TEMP_INIT  = 8'h02,
  parameter logic [7:0] PROTO_INIT = 8'h59
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // store side
  output logic            nvm_load,
  output logic      [7:0] nvm_temp_max,
  output logic      [7:0] nvm_proto_cfg
);
  logic [1:0] wait_ff;

  assign nvm_temp_max  = TEMP_INIT;
  assign nvm_proto_cfg = PROTO_INIT;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_ff  <= 2'h0;
      nvm_load <= 1'b0;
    end else begin
      if (wait_ff != 2'h3) begin
        wait_ff <= wait_ff + 2'h1;
      end
      nvm_load <= (wait_ff == 2'h2);
    end
  end
endmodule

// *** testbench/vid_link_config_registers_test.sv ***
`timescale 1ns/1ps
`include "vid_cfg_consts.svh"

module vid_link_config_registers_test;
  logic       core_clk = 1'b0, rst_b = 1'b0, wr_req = 1'b0, rd_req = 1'b0;
  logic [7:0] cmd_code = 8'h00, wr_data = 8'h00;
  logic       conv_enabled = 1'b0;
  logic [1:0] voltage_control_source = 2'h0;
  logic       cmd_hit, wr_ack, wr_nack, nvm_load, link_ready, vboot_apply;
  logic       answer_bcast_e, answer_bcast_f;
  logic [7:0] rd_data, nvm_temp_max, nvm_proto_cfg, link_temp_max;
  logic [7:0] link_protocol_select, link_vboot_vid, broadcast_activation_reg;
  logic [7:0] temp_max_report_c;
  logic [3:0] output_voltage_setpoint_step_mv, vboot_code;
  int         fail_count = 0, checks = 0;
  logic       ack_s, nack_s, hit_s;
  logic [7:0] proto_code [4] = '{8'h04, 8'h07, 8'h09, 8'h04};

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  vid_cfg_store_model store (.core_clk(core_clk), .rst_b(rst_b),
    .nvm_load(nvm_load), .nvm_temp_max(nvm_temp_max),
    .nvm_proto_cfg(nvm_proto_cfg));

  vid_link_config_registers dut (.core_clk(core_clk), .rst_b(rst_b),
    .wr_req(wr_req), .rd_req(rd_req), .cmd_code(cmd_code),
    .wr_data(wr_data), .cmd_hit(cmd_hit), .wr_ack(wr_ack),
    .wr_nack(wr_nack), .rd_data(rd_data), .nvm_load(nvm_load),
    .nvm_temp_max(nvm_temp_max), .nvm_proto_cfg(nvm_proto_cfg),
    .conv_enabled(conv_enabled),
    .voltage_control_source(voltage_control_source),
    .link_ready(link_ready), .link_temp_max(link_temp_max),
    .link_protocol_select(link_protocol_select),
    .link_vboot_vid(link_vboot_vid),
    .broadcast_activation_reg(broadcast_activation_reg),
    .temp_max_report_c(temp_max_report_c),
    .output_voltage_setpoint_step_mv(output_voltage_setpoint_step_mv),
    .vboot_code(vboot_code), .vboot_apply(vboot_apply),
    .answer_bcast_e(answer_bcast_e), .answer_bcast_f(answer_bcast_f));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(posedge core_clk);
    wr_req   <= 1'b1;
    cmd_code <= cmd;
    wr_data  <= data;
    #1;
    ack_s  = wr_ack;
    nack_s = wr_nack;
    hit_s  = cmd_hit;
    @(posedge core_clk);
    wr_req <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    @(posedge core_clk);
    rd_req   <= 1'b1;
    cmd_code <= cmd;
    @(posedge core_clk);
    rd_req <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // store contents reach registers and link copies
  task automatic t_load();
    settle(5);
    chk({7'h0, link_ready}, 8'h01);
    rd_chk(`CMD_TEMP_MAX_DEFAULT, 8'h02);
    rd_chk(`CMD_PROTO_BOOT_BCAST, 8'h59);
    chk(link_protocol_select, 8'h07);
    chk(link_vboot_vid, 8'h97);
    chk({6'h0, answer_bcast_e, answer_bcast_f}, 8'h01);
  endtask

  // every temperature code, reserved bits set on write
  task automatic t_temp();
    for (int i = 0; i < 8; i++) begin
      wr(`CMD_TEMP_MAX_DEFAULT, 8'hf8 | 8'(i));
      chk({6'h0, ack_s, nack_s}, 8'h02);
      chk({7'h0, hit_s}, 8'h01);
      settle(1);
      chk(link_temp_max, 8'(i));
      chk(temp_max_report_c, 8'(95 + 5 * i));
      rd_chk(`CMD_TEMP_MAX_DEFAULT, 8'(i));
    end
  endtask

  // boot code against step size for every protocol code
  task automatic t_proto();
    logic [7:0] last;
    logic [3:0] b;
    logic       ok, ten;
    last = 8'h59;
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 2; k++) begin
        b   = k ? 4'hd : 4'h6;
        ten = (p == 0 || p == 3);
        ok  = (ten == (b >= 4'hd));
        wr(`CMD_PROTO_BOOT_BCAST, {2'(p), b, 2'h1});
        chk({6'h0, ack_s, nack_s}, ok ? 8'h02 : 8'h01);
        if (ok) begin
          last = {2'(p), b, 2'h1};
        end
        settle(3);
        rd_chk(`CMD_PROTO_BOOT_BCAST, last);
        if (ok) begin
          chk(link_protocol_select, proto_code[p]);
          chk(8'(output_voltage_setpoint_step_mv), ten ? 8'h0a : 8'h05);
          chk(link_vboot_vid, k ? 8'h6f : 8'h97);
        end
      end
    end
  endtask

  // protocol and broadcast held while converting, boot updates at once
  task automatic t_hold();
    @(posedge core_clk);
    conv_enabled <= 1'b1;
    wr(`CMD_PROTO_BOOT_BCAST, 8'ha2);
    chk({7'h0, ack_s}, 8'h01);
    settle(2);
    chk(8'(vboot_code), 8'h08);
    chk(link_vboot_vid, 8'hab);
    chk(link_protocol_select, 8'h04);
    chk({6'h0, answer_bcast_e, answer_bcast_f}, 8'h01);
    rd_chk(`CMD_PROTO_BOOT_BCAST, 8'ha2);
    @(posedge core_clk);
    conv_enabled <= 1'b0;
    settle(3);
    chk(link_protocol_select, 8'h09);
    chk(broadcast_activation_reg, 8'h02);
    for (int a = 0; a < 4; a++) begin
      wr(`CMD_PROTO_BOOT_BCAST, {6'h18, 2'(a)});
      settle(3);
      chk({6'h0, answer_bcast_e, answer_bcast_f}, 8'(a));
      chk(broadcast_activation_reg, 8'(a));
    end
  endtask

  // control source decides whether boot voltage applies; unmapped code
  task automatic t_misc();
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      voltage_control_source <= 2'(s);
      settle(1);
      chk({7'h0, vboot_apply}, (s < 2) ? 8'h01 : 8'h00);
    end
    wr(8'hc3, 8'h55);
    chk({6'h0, ack_s, nack_s}, 8'h00);
    chk({7'h0, hit_s}, 8'h00);
    rd_chk(8'hc3, 8'h00);
  endtask

  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    t_load();
    t_temp();
    t_proto();
    t_hold();
    t_misc();
    wrap_up();
  end
endmodule
